//--- design/drm_regs.svh
// register offsets, field positions, reset values and level limits of the range monitor
`ifndef DRM_REGS_SVH
`define DRM_REGS_SVH
`define DRM_NCH 2
`define DRM_SW 14
`define DRM_FIFO_DEPTH 16
`define DRM_DECAY_SAMPLES 16'h0400
// register offsets
`define DRM_OFS_CHAN 12'h008
`define DRM_OFS_MODE 12'h430
`define DRM_OFS_TUNE 12'h434
`define DRM_OFS_PINS 12'h559
// reset values
`define DRM_RST_CHAN 8'h03
`define DRM_RST_MODE 8'h00
`define DRM_RST_TUNE 8'h04
`define DRM_RST_PINS 8'h00
// mode fields
`define DRM_MODE_EN 0
`define DRM_MODE_CPLX 1
`define DRM_MODE_BW43 2
// status pin source fields
`define DRM_PIN_SRC 1:0
`define DRM_PIN_ROUTE 2
`define DRM_SRC_PUNISH 2'h1
`define DRM_SRC_HILO 2'h2
// serial frame: 16 instruction bits, 8 data bits
`define DRM_SPI_INSTR_BITS 5'h10
`define DRM_SPI_LAST_BIT 5'h17
`define DRM_SPI_DONE 5'h18
`define DRM_SPI_RD 15
// peak limits for 14-bit full scale: -30, -24, -18, -12, -6 dBFS
`define DRM_LVL_30 14'h0103
`define DRM_LVL_24 14'h0205
`define DRM_LVL_18 14'h0407
`define DRM_LVL_12 14'h0809
`define DRM_LVL_6 14'h1009
`define DRM_MAX_DROP 3'h5
`define DRM_PUNISH_DROP 3'h2
`endif

//--- design/drm_pkg.sv
// types shared by the range monitor files
`include "drm_regs.svh"
package drm_pkg;
    typedef logic [`DRM_SW-1:0] drm_sample_t;
    typedef logic [2:0] drm_drop_t;
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sclk_d;
        logic [4:0] cnt;
        logic [15:0] instr;
        logic [7:0] shift;
        logic [7:0] chan;
        logic [`DRM_NCH-1:0][7:0] mode;
        logic [`DRM_NCH-1:0][7:0] tune;
        logic [`DRM_NCH-1:0][7:0] pins;
        logic [`DRM_NCH-1:0][3:0] phase;
        logic [`DRM_NCH-1:0][2:0][14:0] hist;
        logic [`DRM_NCH-1:0][13:0] peak;
        logic [15:0] dcnt;
        logic [`DRM_NCH-1:0][2:0] drop;
    } drm_state_t;
endpackage : drm_pkg

//--- design/drm_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module drm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] fill;
    } drm_fifo_state_t;
    drm_fifo_state_t cur, next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // ------------------------------------------------------------
    // handshake and pointers
    // ------------------------------------------------------------
    assign in_ready = (cur.fill != (AW+1)'(DEPTH));
    assign out_valid = (cur.fill != '0);
    assign out_data = mem[cur.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer wrap works for any depth, not only powers of two
    always_comb begin
        next = cur;
        if (push) begin
            next.wr = (cur.wr == AW'(DEPTH-1)) ? '0 : cur.wr + 1'b1;
        end
        if (pop) begin
            next.rd = (cur.rd == AW'(DEPTH-1)) ? '0 : cur.rd + 1'b1;
        end
        next.fill = cur.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    // storage holds no reset, only the pointers and the fill count do
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[cur.wr] <= in_data;
        end
    end

    chk_fill_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
        cur.fill <= (AW+1)'(DEPTH)) else $error("fifo fill above depth");
endmodule : drm_fifo
`default_nettype wire

//--- design/drm_monitor.sv
// per-channel dynamic range monitor: serial registers, mask estimator, bit trimming, status pins
`timescale 1ns/10ps
`default_nettype none
`include "drm_regs.svh"
// What this block does
// - keep 14 bits in band and never fewer than 9 bits anywhere.
// - when enabled, no gain change; only the count of valid bits changes.
// - each channel has its own enable and settings through the serial port.
// - complex mode at 25% or 43% bandwidth; real mode at 25% only.
// - mode register picks operating mode and bandwidth, which sets the mask zones.
// - reduction comes from peak level in the disallowed zones, not in band.
// - zone level at or below -30 dBFS keeps full 14-bit output.
// - each further 6 dB drops one more bit, down to 9 bits.
// - status pin register picks punish or high/low indicator on the pins.
// - only one indicator reaches the pins at a time.
// - high/low indicator is 1 when reduced, 0 at full resolution.
// - punish indicator is 0 at 14 or 13 bits, 1 at 12 or fewer.
// - four-bit tuning word in bits 3:0 sets centre in steps of rate/16.
// - complex mode centre tunes from 1/16 to 15/16 of the rate.
// - real mode band sits at word*rate/16, one eighth rate each side.
// - real mode zones are the band below and above the protected band.
module drm_monitor #(
    parameter int FIFO_DEPTH = `DRM_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic spi_sclk,
    input wire logic spi_csb_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    input wire logic in_valid,
    output logic in_ready,
    input wire drm_pkg::drm_sample_t in_data_a,
    input wire drm_pkg::drm_sample_t in_data_b,
    output logic out_valid,
    input wire logic out_ready,
    output drm_pkg::drm_sample_t out_data_a,
    output drm_pkg::drm_sample_t out_data_b,
    output logic [`DRM_NCH-1:0] ovr_pin,
    output logic [`DRM_NCH-1:0] status_pin
);
    import drm_pkg::*;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // cosine of k*2pi/16 scaled by 127
    function automatic logic signed [7:0] cos_lut(input logic [3:0] k);
        case (k)
            4'h0: cos_lut = 8'sh7F;
            4'h1, 4'hF: cos_lut = 8'sh75;
            4'h2, 4'hE: cos_lut = 8'sh5A;
            4'h3, 4'hD: cos_lut = 8'sh31;
            4'h4, 4'hC: cos_lut = 8'sh00;
            4'h5, 4'hB: cos_lut = -8'sh31;
            4'h6, 4'hA: cos_lut = -8'sh5A;
            4'h7, 4'h9: cos_lut = -8'sh75;
            default: cos_lut = -8'sh7F;
        endcase
    endfunction : cos_lut

    // number of bits to discard for a zone peak, one per 6 dB above -30 dBFS
    function automatic drm_drop_t level_of(input logic [13:0] pk);
        if (pk <= `DRM_LVL_30) level_of = 3'h0;
        else if (pk <= `DRM_LVL_24) level_of = 3'h1;
        else if (pk <= `DRM_LVL_18) level_of = 3'h2;
        else if (pk <= `DRM_LVL_12) level_of = 3'h3;
        else if (pk <= `DRM_LVL_6) level_of = 3'h4;
        else level_of = `DRM_MAX_DROP;
    endfunction : level_of

    // clears the discarded low bits and leaves the sample format alone
    function automatic drm_sample_t trim(input drm_sample_t s, input drm_drop_t d);
        trim = s & (14'h3FFF << d);
    endfunction : trim

    function automatic logic [7:0] reg_read(input drm_state_t st, input logic [11:0] a);
        logic ch;
        ch = !st.chan[0];
        case (a)
            `DRM_OFS_CHAN: reg_read = st.chan;
            `DRM_OFS_MODE: reg_read = st.mode[ch];
            `DRM_OFS_TUNE: reg_read = st.tune[ch];
            `DRM_OFS_PINS: reg_read = st.pins[ch];
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // ------------------------------------------------------------
    // state and datapath signals
    // ------------------------------------------------------------
    drm_state_t cur, next;
    logic accept;
    logic fifo_ready;
    logic [31:0] fifo_din;
    logic [31:0] fifo_dout;
    logic [`DRM_NCH-1:0][13:0] mag;
    logic rise, fall, rd_frame;

    assign accept = in_valid && fifo_ready;
    assign in_ready = fifo_ready;
    assign rise = cur.sync2[2] && !cur.sclk_d;
    assign fall = !cur.sync2[2] && cur.sclk_d;
    assign rd_frame = cur.instr[`DRM_SPI_RD];

    // read data leaves msb first while the frame is in its data phase
    assign spi_sdio_out = cur.shift[7];
    assign spi_sdio_oe = !cur.sync2[1] && rd_frame && (cur.cnt >= `DRM_SPI_INSTR_BITS);

    // ------------------------------------------------------------
    // next state: serial port, mixer, zone filter, peak and drop
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] ins;
        logic [7:0] wdat;
        logic signed [13:0] xs, xo;
        logic signed [22:0] prod;
        logic signed [14:0] m;
        logic signed [16:0] lp;
        logic signed [16:0] hp;
        logic [16:0] amag;
        logic tick;
        ins = '0;
        wdat = '0;
        xs = '0;
        xo = '0;
        prod = '0;
        m = '0;
        lp = '0;
        hp = '0;
        amag = '0;
        tick = 1'b0;
        mag = '0;
        next = cur;
        // all three pins cross into this clock through two flops
        next.sync1 = {spi_sclk, spi_csb_n, spi_sdio_in};
        next.sync2 = cur.sync1;
        next.sclk_d = cur.sync2[2];
        ins = {cur.instr[14:0], cur.sync2[0]};
        wdat = {cur.shift[6:0], cur.sync2[0]};
        if (cur.sync2[1]) begin
            next.cnt = '0;
        end else if (rise && cur.cnt != `DRM_SPI_DONE) begin
            next.cnt = cur.cnt + 5'h1;
            if (cur.cnt < `DRM_SPI_INSTR_BITS) begin
                next.instr = ins;
            end else if (!rd_frame) begin
                next.shift = wdat;
            end
            if (cur.cnt == `DRM_SPI_INSTR_BITS - 5'h1) begin
                next.shift = reg_read(cur, ins[11:0]);
            end
            // a write lands on the last data bit, on every selected channel
            if (cur.cnt == `DRM_SPI_LAST_BIT && !rd_frame) begin
                if (cur.instr[11:0] == `DRM_OFS_CHAN) next.chan = wdat;
                for (int c = 0; c < `DRM_NCH; c++) begin
                    if (cur.chan[c]) begin
                        case (cur.instr[11:0])
                            `DRM_OFS_MODE: next.mode[c] = wdat;
                            `DRM_OFS_TUNE: next.tune[c] = wdat;
                            `DRM_OFS_PINS: next.pins[c] = wdat;
                            default: ;
                        endcase
                    end
                end
            end
        end else if (fall && rd_frame && cur.cnt > `DRM_SPI_INSTR_BITS) begin
            next.shift = {cur.shift[6:0], 1'b0};
        end
        // peak decay runs on a sample count so a burst fades away slowly
        tick = accept && (cur.dcnt == `DRM_DECAY_SAMPLES - 16'h1);
        if (accept) begin
            next.dcnt = tick ? 16'h0 : cur.dcnt + 16'h1;
        end
        for (int c = 0; c < `DRM_NCH; c++) begin
            xs = $signed(c == 0 ? in_data_a : in_data_b);
            xo = $signed(c == 0 ? in_data_b : in_data_a);
            // shift the protected centre down to dc
            prod = 23'(xs * cos_lut(cur.phase[c]));
            if (cur.mode[c][`DRM_MODE_CPLX]) begin
                prod = prod + 23'(xo * cos_lut(cur.phase[c] - 4'h4));
            end
            m = 15'(prod >>> 7);
            // narrow lowpass keeps +-rate/8, the wide one keeps the 43% band
            if (cur.mode[c][`DRM_MODE_BW43] && cur.mode[c][`DRM_MODE_CPLX]) begin
                lp = 17'((17'(m) + 17'($signed(cur.hist[c][0]))) >>> 1);
            end else begin
                lp = 17'((17'(m) + 17'($signed(cur.hist[c][0])) + 17'($signed(cur.hist[c][1]))
                    + 17'($signed(cur.hist[c][2]))) >>> 2);
            end
            // what is left outside the band is the zone content
            hp = 17'(m) - lp;
            amag = hp[16] ? 17'(-hp) : 17'(hp);
            mag[c] = (amag > 17'h03FFF) ? 14'h3FFF : amag[13:0];
            if (accept) begin
                next.hist[c] = {cur.hist[c][1:0], m};
                next.phase[c] = cur.phase[c] + cur.tune[c][3:0];
                if (mag[c] > cur.peak[c]) begin
                    next.peak[c] = mag[c];
                end else if (tick) begin
                    next.peak[c] = cur.peak[c] - (cur.peak[c] >> 4);
                end
            end
            // disabled channels always pass all fourteen bits
            next.drop[c] = cur.mode[c][`DRM_MODE_EN] ? level_of(next.peak[c]) : 3'h0;
        end
    end

    // single state register for the whole block
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cur <= '0;
            cur.sync1 <= 3'h2;
            cur.sync2 <= 3'h2;
            cur.chan <= `DRM_RST_CHAN;
            cur.mode <= {`DRM_NCH{`DRM_RST_MODE}};
            cur.tune <= {`DRM_NCH{`DRM_RST_TUNE}};
            cur.pins <= {`DRM_NCH{`DRM_RST_PINS}};
        end else begin
            cur <= next;
        end
    end

    // ------------------------------------------------------------
    // output buffer: trimmed samples with their indicators
    // ------------------------------------------------------------
    // trimming uses the drop from earlier samples; the estimate lags by a sample
    assign fifo_din = {cur.drop[1] >= `DRM_PUNISH_DROP, cur.drop[1] != 3'h0,
        cur.drop[0] >= `DRM_PUNISH_DROP, cur.drop[0] != 3'h0,
        trim(in_data_b, cur.drop[1]), trim(in_data_a, cur.drop[0])};

    drm_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(in_valid),
        .in_ready(fifo_ready),
        .in_data(fifo_din),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_dout)
    );

    assign out_data_a = fifo_dout[13:0];
    assign out_data_b = fifo_dout[27:14];

    // one source per channel reaches one pin pair only
    always_comb begin
        logic ind;
        ind = 1'b0;
        for (int c = 0; c < `DRM_NCH; c++) begin
            case (cur.pins[c][`DRM_PIN_SRC])
                `DRM_SRC_PUNISH: ind = fifo_dout[28 + 2 * c + 1];
                `DRM_SRC_HILO: ind = fifo_dout[28 + 2 * c];
                default: ind = 1'b0;
            endcase
            ind = ind && out_valid;
            ovr_pin[c] = ind && !cur.pins[c][`DRM_PIN_ROUTE];
            status_pin[c] = ind && cur.pins[c][`DRM_PIN_ROUTE];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_drop_floor: assert property (cur.drop[0] <= `DRM_MAX_DROP && cur.drop[1] <= `DRM_MAX_DROP)
        else $error("more than five bits dropped");
    chk_off_full: assert property (!cur.mode[1][`DRM_MODE_EN] |=> cur.drop[1] == 3'h0)
        else $error("disabled channel trims bits");
    chk_chan_apart: assert property (cur.mode[0][`DRM_MODE_EN] && !cur.mode[1][`DRM_MODE_EN]
        && !accept && cur.peak[0] > `DRM_LVL_6 |=> cur.drop[1] == 3'h0 && cur.drop[0] == `DRM_MAX_DROP)
        else $error("channels not independent");
    chk_quiet_full: assert property (cur.mode[0][`DRM_MODE_EN] && !accept
        && cur.peak[0] <= `DRM_LVL_30 |=> cur.drop[0] == 3'h0) else $error("quiet zone trimmed");
    chk_step_one: assert property (cur.mode[0][`DRM_MODE_EN] && !accept && cur.peak[0] > `DRM_LVL_24
        && cur.peak[0] <= `DRM_LVL_18 |=> cur.drop[0] == 3'h2) else $error("wrong drop step");
    chk_trim_zero: assert property (accept |-> (fifo_din[13:0] & ~(14'h3FFF << cur.drop[0])) == 14'h0)
        else $error("dropped bits not zero");
    chk_pin_excl: assert property (!(ovr_pin[0] && status_pin[0]) && !(ovr_pin[1] && status_pin[1]))
        else $error("indicator on both pins");
    chk_punish_bits: assert property (cur.pins[0][`DRM_PIN_SRC] == `DRM_SRC_PUNISH && ovr_pin[0]
        |-> out_data_a[1:0] == 2'h0) else $error("punish with fewer than two dropped bits");
    chk_hilo_bits: assert property (cur.pins[0][`DRM_PIN_SRC] == `DRM_SRC_HILO && status_pin[0]
        |-> out_data_a[0] == 1'b0) else $error("reduced flag with full resolution");
    chk_pin_idle: assert property (cur.pins[1][`DRM_PIN_SRC] == 2'h0 |-> !ovr_pin[1] && !status_pin[1])
        else $error("pin driven with no source");
    chk_phase_step: assert property (accept |=> cur.phase[0] == 4'($past(cur.phase[0])
        + $past(cur.tune[0][3:0]))) else $error("centre phase step wrong");

    cov_full_trim: cover property (cur.drop[0] == `DRM_MAX_DROP);
    cov_punish_pin: cover property (ovr_pin[0]);
    cov_reg_write: cover property (rise && cur.cnt == `DRM_SPI_LAST_BIT && !rd_frame && !cur.sync2[1]);
    cov_buffer_full: cover property (in_valid && !fifo_ready);
endmodule : drm_monitor
`default_nettype wire

//--- bench/drm_rx_model.sv
// receiving logic model: takes output sample pairs and indicator pins
`timescale 1ns/10ps
`default_nettype none
module drm_rx_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire drm_pkg::drm_sample_t out_data_a,
    input wire drm_pkg::drm_sample_t out_data_b,
    input wire logic [1:0] ovr_pin,
    input wire logic [1:0] status_pin
);
    import drm_pkg::*;
    drm_sample_t cap_a[$];
    drm_sample_t cap_b[$];
    logic [3:0] cap_p[$];
    // ready follows the stall request a cycle late, like a registered sink
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
        end
    end
    // a word counts only at an edge with valid and ready both high
    always @(posedge ref_clk) begin
        if (rstn && out_valid && out_ready) begin
            cap_a.push_back(out_data_a);
            cap_b.push_back(out_data_b);
            cap_p.push_back({ovr_pin, status_pin});
        end
    end
endmodule : drm_rx_model
`default_nettype wire

//--- bench/variable_dynamic_range_monitor_bench.sv
// self-checking bench: registers, buffer, bit trimming and indicator pins
`timescale 1ns/10ps
`default_nettype none
`define DRM_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t ns: got %h expected %h", $time, got, exp); end end
module variable_dynamic_range_monitor_bench;
    import drm_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } drm_row_t;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_csb_n = 1'b1;
    logic host_bit = 1'b0;
    logic spi_sdio_out, spi_sdio_oe, spi_sdio_in;
    logic in_valid = 1'b0;
    logic in_ready, out_valid, out_ready;
    logic stall = 1'b0;
    drm_sample_t in_data_a = '0;
    drm_sample_t in_data_b = '0;
    drm_sample_t out_data_a, out_data_b;
    logic [1:0] ovr_pin, status_pin;
    int n_mismatch = 0;
    int checked = 0;
    drm_sample_t exp_a[$];
    drm_sample_t exp_b[$];
    logic [3:0] exp_p[$];
    logic [7:0] rd;
    drm_row_t rows[11] = '{
        '{1'b1, 12'h008, 8'h01, 8'h01}, '{1'b1, 12'h430, 8'h07, 8'h07},
        '{1'b1, 12'h008, 8'h02, 8'h02}, '{1'b1, 12'h430, 8'h03, 8'h03},
        '{1'b1, 12'h434, 8'h0F, 8'h0F}, '{1'b1, 12'h008, 8'h01, 8'h01},
        '{1'b0, 12'h430, 8'h00, 8'h07}, '{1'b1, 12'h434, 8'h01, 8'h01},
        '{1'b1, 12'h559, 8'h06, 8'h06}, '{1'b1, 12'h123, 8'h5A, 8'h00},
        '{1'b1, 12'h008, 8'h03, 8'h03}};

    // --------------------------------------------------------------
    // clock, wire and instances
    // --------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    // the shared data wire: the device wins while it drives
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : host_bit;
    drm_monitor #(.FIFO_DEPTH(16)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_csb_n(spi_csb_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .in_valid(in_valid), .in_ready(in_ready), .in_data_a(in_data_a),
        .in_data_b(in_data_b), .out_valid(out_valid), .out_ready(out_ready), .out_data_a(out_data_a),
        .out_data_b(out_data_b), .ovr_pin(ovr_pin), .status_pin(status_pin));
    drm_rx_model i_rx (.ref_clk(ref_clk), .rstn(rstn), .stall(stall), .out_valid(out_valid),
        .out_ready(out_ready), .out_data_a(out_data_a), .out_data_b(out_data_b), .ovr_pin(ovr_pin),
        .status_pin(status_pin));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // one frame; six-cycle low and seven-cycle high phases leave room for the synchroniser lag
    task automatic spi(input logic is_rd, input logic [11:0] addr, input logic [7:0] wdata);
        logic [23:0] frame;
        frame = {is_rd, 3'h0, addr, wdata};
        spi_csb_n <= 1'b0;
        cyc(6);
        for (int i = 23; i >= 0; i--) begin
            host_bit <= frame[i];
            cyc(6);
            spi_sclk <= 1'b1;
            cyc(6);
            @(negedge ref_clk);
            // read bit i is held through the high phase of its own clock pulse
            if (i <= 7) begin
                rd[i] = spi_sdio_out;
            end
            @(posedge ref_clk);
            spi_sclk <= 1'b0;
        end
        cyc(8);
        spi_csb_n <= 1'b1;
        host_bit <= ~host_bit;
        cyc(6);
    endtask : spi
    task automatic wr(input logic [11:0] addr, input logic [7:0] d);
        spi(1'b0, addr, d);
    endtask : wr
    task automatic rdr(input logic [11:0] addr, input logic [7:0] e);
        spi(1'b1, addr, 8'h00);
        `DRM_CHK(rd, e)
    endtask : rdr
    // leaves valid high so that pushes run back to back
    task automatic push(input drm_sample_t a, input drm_sample_t b);
        logic r;
        in_valid <= 1'b1;
        in_data_a <= a;
        in_data_b <= b;
        for (int k = 0; k < 2000; k++) begin
            @(negedge ref_clk);
            r = in_ready;
            @(posedge ref_clk);
            if (r) return;
        end
        n_mismatch++;
        $display("mismatch at %0t ns: sample never taken", $time);
    endtask : push
    task automatic idle;
        in_valid <= 1'b0;
        @(posedge ref_clk);
    endtask : idle
    task automatic expq(input drm_sample_t a, input drm_sample_t b, input logic [3:0] p);
        exp_a.push_back(a);
        exp_b.push_back(b);
        exp_p.push_back(p);
    endtask : expq
    // waits, bounded, for every expected word, then compares in order
    task automatic drain;
        drm_sample_t a;
        drm_sample_t b;
        logic [3:0] p;
        logic [31:0] g;
        for (int k = 0; k < 3000 && i_rx.cap_a.size() < exp_a.size(); k++) @(posedge ref_clk);
        `DRM_CHK(i_rx.cap_a.size(), exp_a.size())
        while (exp_a.size() > 0 && i_rx.cap_a.size() > 0) begin
            a = exp_a.pop_front();
            b = exp_b.pop_front();
            p = exp_p.pop_front();
            // pop once into a local so the compare macro does not pop twice on a mismatch
            g = {i_rx.cap_a.pop_front(), i_rx.cap_b.pop_front(), i_rx.cap_p.pop_front()};
            `DRM_CHK(g, {a, b, p})
        end
    endtask : drain
    task automatic probe(input drm_sample_t a, input drm_sample_t b, input drm_sample_t ea,
        input drm_sample_t eb, input logic [3:0] p);
        push(a, b);
        idle();
        expq(ea, eb, p);
        drain();
    endtask : probe
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    // about 33 frames of 332 cycles each; the limit leaves over fourfold room
    initial begin
        #2000000;
        n_mismatch++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        close_out();
    end
    initial begin
        drm_sample_t v;
        cyc(6);
        rstn <= 1'b1;
        @(negedge ref_clk);
        `DRM_CHK({in_ready, out_valid, ovr_pin, status_pin, spi_sdio_oe}, 7'h40)
        cyc(3);
        rdr(12'h008, 8'h03);
        rdr(12'h430, 8'h00);
        rdr(12'h434, 8'h04);
        rdr(12'h559, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].wdata);
            end
            rdr(rows[i].addr, rows[i].rexp);
        end
        $display("test registers done");
        // disabled monitor passes samples whole; fill to refusal while stalled
        wr(12'h430, 8'h00);
        wr(12'h559, 8'h06);
        stall <= 1'b1;
        cyc(3);
        for (int i = 0; i < 17; i++) begin
            v = 14'(i * 14'h0401) ^ 14'h2000;
            if (i == 16) begin
                in_data_a <= v;
                in_data_b <= ~v;
                @(negedge ref_clk);
                `DRM_CHK({in_ready, out_valid}, 2'h1)
                @(posedge ref_clk);
                stall <= 1'b0;
            end
            push(v, ~v);
            expq(v, ~v, 4'h0);
        end
        idle();
        drain();
        $display("test buffer done");
        // real mode, band at quarter rate; strong dc on A sits in the lower zone
        // channel B stays off so it passes whole beside the trimmed channel A
        wr(12'h008, 8'h01);
        wr(12'h430, 8'h01);
        wr(12'h434, 8'h04);
        for (int i = 0; i < 300; i++) push(14'h1FFF, 14'h0000);
        idle();
        cyc(40);
        i_rx.cap_a.delete();
        i_rx.cap_b.delete();
        i_rx.cap_p.delete();
        probe(14'h1ABC, 14'h0ABC, 14'h1AA0, 14'h0ABC, 4'h1);
        wr(12'h008, 8'h01);
        wr(12'h559, 8'h01);
        probe(14'h2ABC, 14'h0ABC, 14'h2AA0, 14'h0ABC, 4'h4);
        wr(12'h430, 8'h00);
        probe(14'h1ABC, 14'h0ABC, 14'h1ABC, 14'h0ABC, 4'h0);
        $display("test trimming done");
        close_out();
    end
endmodule : variable_dynamic_range_monitor_bench
`default_nettype wire
